// ---- design/dsbp_pkg.sv ----
/*
 * Shared constants and types of the double-rate burst SRAM port.
 * Assumes one system clock that runs both ends of the link.
 */
package dsbp_pkg;

    localparam int LANE_W        = 9;
    localparam int DQ_W_NARROW   = 18;
    localparam int DQ_W_WIDE     = 36;
    localparam int ADDR_W_NARROW = 20;
    localparam int ADDR_W_WIDE   = 19;
    localparam int BURST_LEN     = 2;
    localparam int SPARE_W       = 3;
    localparam int FIFO_DEPTH    = 16;
    localparam int STB_HALF      = 4;

    localparam logic [2:0] PH_DATA0    = 3'h2;
    localparam logic [2:0] PH_LOAD     = 3'h6;
    localparam logic [2:0] PH_RD_BEAT0 = 3'h2;
    localparam logic [2:0] PH_RD_BEAT1 = 3'h6;

    localparam logic LOAD_IDLE = 1'h1;
    localparam logic DIR_READ  = 1'h1;
    localparam logic DIR_WRITE = 1'h0;

    typedef enum logic [1:0] {
        dev_idle,
        dev_beat0,
        dev_beat1
    } dsbp_dev_state_type;

    typedef enum logic [1:0] {
        ctl_idle,
        ctl_beat0,
        ctl_beat1,
        ctl_tail
    } dsbp_ctl_state_type;

endpackage

// ---- design/dsbp_link_if.sv ----
/*
 * Pin-level link between the memory controller and the burst SRAM.
 * Assumes both ends use the same clock; the shared data wire is
 * resolved here from the two output enables.
 */
interface dsbp_link_if #(
    parameter int DQ_W   = 18,
    parameter int ADDR_W = 20
);
    import dsbp_pkg::*;
    localparam int LANES = DQ_W / LANE_W;

    logic               k;
    logic               k_n;
    logic               load_n;
    logic               dir_select;
    logic [ADDR_W-1:0]  addr;
    logic [DQ_W-1:0]    dq_ctl;
    logic               dq_ctl_oe;
    logic [DQ_W-1:0]    dq_dev;
    logic               dq_dev_oe;
    logic [DQ_W-1:0]    dq;
    logic [LANES-1:0]   lane_write_sel_n;
    logic               out_valid_flag;
    logic               term_enable;
    logic [SPARE_W-1:0] spare_balls;

    // The wire reads low when nobody drives it.
    assign dq = dq_ctl_oe ? dq_ctl : (dq_dev_oe ? dq_dev : '0);

    modport ctl (
        output k, k_n, load_n, dir_select, addr, dq_ctl, dq_ctl_oe,
        output lane_write_sel_n, spare_balls,
        input  dq, out_valid_flag, term_enable
    );

    modport dev (
        input  k, k_n, load_n, dir_select, addr, dq, lane_write_sel_n,
        output dq_dev, dq_dev_oe, out_valid_flag, term_enable
    );

endinterface

// ---- design/dsbp_fifo.sv ----
/*
 * Synchronous FIFO with valid and ready on both sides.
 * Assumes DEPTH is a power of two.
 */
module dsbp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset.
    input  wire logic             clock,
    input  wire logic             rst,
    // Filling side.
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr_q;
    logic [PW-1:0]    rd_ptr_q;
    logic [PW:0]      count_q;
    logic [PW:0]      count_d;
    logic             push;
    logic             pop;

    assign push      = in_valid && in_ready;
    assign pop       = out_ready && out_valid;
    assign out_data  = mem[rd_ptr_q];

    always_comb begin
        count_d = count_q;
        if (push && !pop) begin
            count_d = count_q + 1'b1;
        end else if (pop && !push) begin
            count_d = count_q - 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr_q] <= in_data;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q   <= '0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            wr_ptr_q  <= wr_ptr_q + PW'(push);
            rd_ptr_q  <= rd_ptr_q + PW'(pop);
            count_q   <= count_d;
            in_ready  <= (count_d != (PW+1)'(DEPTH));
            out_valid <= (count_d != '0);
        end
    end

endmodule // dsbp_fifo

// ---- design/dsbp_controller.sv ----
/*
 * Controller end: queues user requests and runs them over the link.
 * Assumes the SRAM end samples every pin through two flip-flops.
 */
module dsbp_controller import dsbp_pkg::*; #(
    parameter int DQ_W   = DQ_W_NARROW,
    parameter int ADDR_W = ADDR_W_NARROW,
    parameter int DEPTH  = FIFO_DEPTH
) (
    // Clock and reset.
    input  wire logic              clock,
    input  wire logic              rst,
    // Link to the SRAM.
    dsbp_link_if.ctl               link,
    // Request queue.
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire logic              req_write,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DQ_W-1:0]   req_data0,
    input  wire logic [DQ_W-1:0]   req_data1,
    input  wire logic [DQ_W/LANE_W-1:0] req_lanes_n0,
    input  wire logic [DQ_W/LANE_W-1:0] req_lanes_n1,
    // Read answers.
    output logic                   rd_valid,
    output logic [DQ_W-1:0]        rd_data0,
    output logic [DQ_W-1:0]        rd_data1
);
    localparam int LANES = DQ_W / LANE_W;
    localparam int EW    = 1 + ADDR_W + 2 * DQ_W + 2 * LANES;

    dsbp_ctl_state_type state_q;
    logic [2:0]        phase_q;
    logic [2:0]        phase_d;
    logic [EW-1:0]     entry_in;
    logic [EW-1:0]     entry;
    logic              entry_valid;
    logic              take;
    logic              cur_write_q;
    logic [DQ_W-1:0]   cur_data1_q;
    logic [LANES-1:0]  cur_lanes1_q;
    logic              e_write;
    logic [ADDR_W-1:0] e_addr;
    logic [DQ_W-1:0]   e_data0;
    logic [DQ_W-1:0]   e_data1;
    logic [LANES-1:0]  e_lanes0;
    logic [LANES-1:0]  e_lanes1;
    logic [1:0]        rd_hist_q;
    logic [DQ_W:0]     in_sync1_q;
    logic [DQ_W:0]     in_sync2_q;
    logic [DQ_W-1:0]   dq_s;
    logic              valid_s;
    logic [DQ_W-1:0]   entry_hold_data0;
    logic [LANES-1:0]  entry_hold_lanes0;

    assign entry_in = {req_write, req_addr, req_data0, req_data1,
                       req_lanes_n0, req_lanes_n1};
    assign {e_write, e_addr, e_data0, e_data1, e_lanes0, e_lanes1} = entry;

    dsbp_fifo #(
        .WIDTH (EW),
        .DEPTH (DEPTH)
    ) u_queue (
        .clock     (clock),
        .rst       (rst),
        .in_valid  (req_valid),
        .in_ready  (req_ready),
        .in_data   (entry_in),
        .out_valid (entry_valid),
        .out_ready (take),
        .out_data  (entry)
    );

    // One load per two true strobe rises.
    assign take = entry_valid && (phase_q == PH_LOAD) &&
                  (state_q == ctl_idle || state_q == ctl_tail);
    assign phase_d = phase_q + 3'h1;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            phase_q <= '0;
            link.k <= 1'b0;
            link.k_n <= 1'b1;
        end else begin
            phase_q <= phase_d;
            link.k <= (phase_d < 3'(STB_HALF));
            link.k_n <= !(phase_d < 3'(STB_HALF));
        end
    end

    // Reads and writes share one address bus; address and direction set before a true rise.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= ctl_idle;
            link.load_n <= LOAD_IDLE;
            link.dir_select <= DIR_READ;
            link.addr <= '0;
            cur_write_q <= 1'b0;
            cur_data1_q <= '0;
            cur_lanes1_q <= '1;
        end else if (phase_q == PH_LOAD) begin
            link.load_n <= LOAD_IDLE;
            if (take) begin
                state_q <= ctl_beat0;
                link.load_n <= 1'b0;
                link.dir_select <= e_write ? DIR_WRITE : DIR_READ;
                link.addr <= e_addr;
                cur_write_q <= e_write;
                cur_data1_q <= e_data1;
                cur_lanes1_q <= e_lanes1;
            end else if (state_q == ctl_beat1) begin
                state_q <= ctl_tail;
            end else if (state_q == ctl_tail) begin
                state_q <= ctl_idle;
            end
        end else if (phase_q == PH_DATA0 && state_q == ctl_beat0) begin
            state_q <= ctl_beat1;
        end
    end

    // Write beats: lane selects travel with their data.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            link.dq_ctl <= '0;
            link.dq_ctl_oe <= 1'b0;
            link.lane_write_sel_n <= '1;
        end else if (phase_q == PH_DATA0) begin
            link.dq_ctl_oe <= (state_q == ctl_beat0) && cur_write_q;
            link.dq_ctl <= entry_hold_data0;
            link.lane_write_sel_n <= '1;
            if (state_q == ctl_beat0 && cur_write_q) begin
                link.lane_write_sel_n <= entry_hold_lanes0;
            end
        end else if (phase_q == PH_LOAD && state_q == ctl_beat1) begin
            link.dq_ctl <= cur_data1_q;
            link.lane_write_sel_n <= cur_write_q ? cur_lanes1_q : '1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            entry_hold_data0 <= '0;
            entry_hold_lanes0 <= '1;
        end else if (take) begin
            entry_hold_data0 <= e_data0;
            entry_hold_lanes0 <= e_lanes0;
        end
    end

    // Spare balls may sit at any level.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            link.spare_balls <= '0;
        end else begin
            link.spare_balls <= '0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            in_sync1_q <= '0;
            in_sync2_q <= '0;
        end else begin
            in_sync1_q <= {link.out_valid_flag, link.dq};
            in_sync2_q <= in_sync1_q;
        end
    end
    assign {valid_s, dq_s} = in_sync2_q;

    // Read answer: even word first, then odd word.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_hist_q <= '0;
            rd_valid <= 1'b0;
            rd_data0 <= '0;
            rd_data1 <= '0;
        end else begin
            rd_valid <= 1'b0;
            if (phase_q == PH_LOAD) begin
                rd_hist_q <= {rd_hist_q[0], take && !e_write};
            end
            if (phase_q == PH_RD_BEAT0 && rd_hist_q[1] && valid_s) begin
                rd_data0 <= dq_s;
            end
            if (phase_q == PH_RD_BEAT1 && rd_hist_q[1] && valid_s) begin
                rd_data1 <= dq_s;
                rd_valid <= 1'b1;
            end
        end
    end

endmodule // dsbp_controller

// ---- design/dsbp_device.sv ----
/*
 * SRAM end: two-word burst memory behind the double-rate link.
 * Assumes the controller keeps loads two true strobe rises apart and
 * holds pins steady around each strobe rise.
 */
module dsbp_device import dsbp_pkg::*; #(
    parameter int DQ_W   = DQ_W_NARROW,
    parameter int ADDR_W = ADDR_W_NARROW
) (
    // Clock and reset.
    input  wire logic           clock,
    input  wire logic           rst,
    // Link to the controller.
    dsbp_link_if.dev            link,
    // Access report to local logic.
    output logic                access_pulse,
    output logic                access_write,
    output logic [ADDR_W-1:0]   access_addr
);
    // Narrow default is 2M x 18, wide is 1M x 36.
    localparam int LANES = DQ_W / LANE_W;
    localparam int DEPTH = 2 ** ADDR_W;
    localparam int IN_W  = 4 + ADDR_W + DQ_W + LANES;
    // Idle pin levels, so no false strobe edge or load follows reset.
    localparam logic [IN_W-1:0] IN_IDLE = {1'b0, 1'b1, LOAD_IDLE, DIR_READ,
        ADDR_W'(0), DQ_W'(0), {LANES{1'b1}}};

    // Two equal arrays: even and odd word of each address.
    logic [DQ_W-1:0]    mem_even [DEPTH];
    logic [DQ_W-1:0]    mem_odd  [DEPTH];

    logic [IN_W-1:0]    in_raw;
    logic [IN_W-1:0]    sync1_q;
    logic [IN_W-1:0]    sync2_q;
    logic               k_s;
    logic               kn_s;
    logic               load_n_s;
    logic               dir_s;
    logic [ADDR_W-1:0]  addr_s;
    logic [DQ_W-1:0]    dq_s;
    logic [LANES-1:0]   lanes_n_s;
    logic               k_prev_q;
    logic               kn_prev_q;
    logic               rise_k;
    logic               rise_kn;
    logic               load_now;

    dsbp_dev_state_type state_q;
    logic [ADDR_W-1:0]  addr_q;
    logic               write_q;
    logic               wr_even;
    logic               wr_odd;
    logic               rd_even;
    logic               rd_odd;

    assign in_raw = {link.k, link.k_n, link.load_n, link.dir_select,
                     link.addr, link.dq, link.lane_write_sel_n};

    // Every pin passes two flip-flops before any logic reads it.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sync1_q <= IN_IDLE;
            sync2_q <= IN_IDLE;
        end else begin
            sync1_q <= in_raw;
            sync2_q <= sync1_q;
        end
    end

    assign {k_s, kn_s, load_n_s, dir_s, addr_s, dq_s, lanes_n_s} = sync2_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            k_prev_q <= 1'b0;
            kn_prev_q <= 1'b1;
        end else begin
            k_prev_q <= k_s;
            kn_prev_q <= kn_s;
        end
    end

    assign rise_k  = k_s && !k_prev_q;
    assign rise_kn = kn_s && !kn_prev_q;

    // Load is looked at on true strobe rises only.
    assign load_now = rise_k && !load_n_s;

    // Burst sequencing: load, first beat, second beat.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= dev_idle;
            addr_q <= '0;
            write_q <= 1'b0;
        end else if (rise_k) begin
            if (load_now) begin
                state_q <= dev_beat0;
                addr_q <= addr_s;
                write_q <= (dir_s == DIR_WRITE);
            end else if (state_q == dev_beat1) begin
                state_q <= dev_idle;
            end
        end else if (rise_kn && state_q == dev_beat0) begin
            state_q <= dev_beat1;
        end
    end

    // First beat on the complement rise, second on the true rise.
    assign wr_even = rise_kn && state_q == dev_beat0 && write_q;
    assign wr_odd  = rise_k && state_q == dev_beat1 && write_q;
    assign rd_even = rise_kn && state_q == dev_beat0 && !write_q;
    assign rd_odd  = rise_k && state_q == dev_beat1 && !write_q;

    // Lane i governs bits i*9+8 down to i*9.
    always_ff @(posedge clock) begin
        for (int i = 0; i < LANES; i++) begin
            // Only selected lanes are stored; others keep data.
            if (wr_even && !lanes_n_s[i]) begin
                mem_even[addr_q][i*LANE_W +: LANE_W] <=
                    dq_s[i*LANE_W +: LANE_W];
            end
            // Select taken at the same edge as its beat.
            if (wr_odd && !lanes_n_s[i]) begin
                mem_odd[addr_q][i*LANE_W +: LANE_W] <=
                    dq_s[i*LANE_W +: LANE_W];
            end
        end
    end

    // Read data driven on both strobe rises.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            link.dq_dev <= '0;
        end else if (rd_even) begin
            link.dq_dev <= mem_even[addr_q];
        end else if (rd_odd) begin
            link.dq_dev <= mem_odd[addr_q];
        end
    end

    // Outputs are enabled for read beats only.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            link.dq_dev_oe <= 1'b0;
        end else if (rise_k || rise_kn) begin
            link.dq_dev_oe <= rd_even || rd_odd;
        end
    end

    // Valid flag follows the driven read beats.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            link.out_valid_flag <= 1'b0;
        end else if (rise_k || rise_kn) begin
            link.out_valid_flag <= rd_even || rd_odd;
        end
    end

    // Termination covers write bursts and is off otherwise.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            link.term_enable <= 1'b0;
        end else if (rise_k) begin
            if (load_now) begin
                link.term_enable <= (dir_s == DIR_WRITE);
            end else if (state_q == dev_beat1) begin
                link.term_enable <= 1'b0;
            end
        end
    end

    // Local report of every accepted load.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            access_pulse <= 1'b0;
            access_write <= 1'b0;
            access_addr <= '0;
        end else begin
            access_pulse <= load_now;
            if (load_now) begin
                access_write <= (dir_s == DIR_WRITE);
                access_addr <= addr_s;
            end
        end
    end

endmodule // dsbp_device

// ---- bench/dsbp_link_sva.sv ----
/*
 * Checker of the pin-level link between controller and burst SRAM.
 * Assumes it is instantiated beside the link interface in tb_top.
 */
module dsbp_link_sva #(
    parameter int DQ_W = 18
) (
    // Clock and reset.
    input wire logic                 clock,
    input wire logic                 rst,
    // Controller drive.
    input wire logic                 k,
    input wire logic                 k_n,
    input wire logic                 load_n,
    input wire logic                 dir_select,
    input wire logic                 dq_ctl_oe,
    input wire logic [DQ_W/9-1:0]    lane_write_sel_n,
    // Device drive.
    input wire logic                 dq_dev_oe,
    input wire logic                 out_valid_flag,
    input wire logic                 term_enable
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    // A load seen at a true strobe rise, read or write.
    sequence rd_load_s;
        $rose(k) && !load_n && dir_select;
    endsequence
    sequence wr_load_s;
        $rose(k) && !load_n && !dir_select;
    endsequence
    // Two beats of four cycles, then release.
    sequence two_beats_s(oe);
        oe[*8] ##1 !oe;
    endsequence

    dq_exclusive_a: assert property (!(dq_ctl_oe && dq_dev_oe))
        else $error("both ends drive the data wire");
    valid_marks_a: assert property (dq_dev_oe == out_valid_flag)
        else $error("valid flag differs from device drive");
    read_beats_a: assert property ($rose(dq_dev_oe) |-> two_beats_s(dq_dev_oe))
        else $error("read burst length wrong");
    read_start_a: assert property (rd_load_s |-> ##[6:8] $rose(dq_dev_oe))
        else $error("read load without read data");
    write_beats_a: assert property ($rose(dq_ctl_oe) |-> two_beats_s(dq_ctl_oe))
        else $error("write burst length wrong");
    write_term_a: assert property (wr_load_s |-> ##[2:4] term_enable)
        else $error("termination not on for write");
    read_noterm_a: assert property (out_valid_flag |-> !term_enable)
        else $error("termination on during read");
    term_cause_a: assert property ($rose(term_enable) |->
        $past(!load_n && !dir_select, 3))
        else $error("termination without write load");
    lane_idle_a: assert property (!dq_ctl_oe |-> &lane_write_sel_n)
        else $error("lane select active outside write beat");
    load_span_a: assert property ($fell(load_n) |-> !load_n[*8] ##1 load_n)
        else $error("load held for wrong span");
    strobe_pair_a: assert property (k_n == !k)
        else $error("strobes not complementary");

    cover property (rd_load_s);
    cover property (wr_load_s);
endmodule // dsbp_link_sva

// ---- bench/tb_top.sv ----
/*
 * Self-checking bench: controller and SRAM ends joined by the link.
 * Assumes the design files and package are compiled first.
 */
module tb_top import dsbp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int AW = 4;
    localparam int DW = DQ_W_NARROW;
    localparam int LN = DW / LANE_W;

    logic              clock = 0;
    logic              rst = 1;
    logic              req_valid, req_ready, req_write, rd_valid;
    logic [AW-1:0]     req_addr, access_addr;
    logic [DW-1:0]     req_data0, req_data1, rd_data0, rd_data1;
    logic [LN-1:0]     req_lanes_n0, req_lanes_n1;
    logic              access_pulse, access_write;
    int                fails, comparisons;
    int                seed = 1;
    bit                saw_full;
    logic [DW-1:0]     mem [2**AW][2];
    logic [2*DW-1:0]   rdq [$];
    logic [AW:0]       accq [$];

    always #2 clock = ~clock;

    dsbp_link_if #(.DQ_W(DW), .ADDR_W(AW)) link ();
    dsbp_controller #(.DQ_W(DW), .ADDR_W(AW), .DEPTH(FIFO_DEPTH))
        i_dsbp_controller (.clock(clock), .rst(rst), .link(link),
        .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_addr(req_addr),
        .req_data0(req_data0), .req_data1(req_data1),
        .req_lanes_n0(req_lanes_n0), .req_lanes_n1(req_lanes_n1),
        .rd_valid(rd_valid), .rd_data0(rd_data0), .rd_data1(rd_data1));
    dsbp_device #(.DQ_W(DW), .ADDR_W(AW)) i_dsbp_device (.clock(clock),
        .rst(rst), .link(link), .access_pulse(access_pulse),
        .access_write(access_write), .access_addr(access_addr));
    dsbp_link_sva #(.DQ_W(DW)) i_dsbp_link_sva (.clock(clock), .rst(rst),
        .k(link.k), .k_n(link.k_n), .load_n(link.load_n),
        .dir_select(link.dir_select), .dq_ctl_oe(link.dq_ctl_oe),
        .lane_write_sel_n(link.lane_write_sel_n),
        .dq_dev_oe(link.dq_dev_oe), .out_valid_flag(link.out_valid_flag),
        .term_enable(link.term_enable));

    task automatic chk(string name, logic [2*DW-1:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Offers one request and notes what it must produce.
    task automatic op(bit wr, logic [AW-1:0] a, logic [LN-1:0] l0, l1);
        logic [DW-1:0] d0;
        logic [DW-1:0] d1;
        int            n;
        d0 = DW'($random(seed));
        d1 = DW'($random(seed));
        req_valid = 1;
        req_write = wr;
        req_addr = a;
        req_data0 = d0;
        req_data1 = d1;
        req_lanes_n0 = l0;
        req_lanes_n1 = l1;
        n = 0;
        @(negedge clock);
        while (!req_ready && n < 400) begin
            saw_full = 1;
            n++;
            @(negedge clock);
        end
        for (int i = 0; i < LN; i++) begin
            if (wr && !l0[i]) mem[a][0][i*LANE_W +: LANE_W] = d0[i*LANE_W +: LANE_W];
            if (wr && !l1[i]) mem[a][1][i*LANE_W +: LANE_W] = d1[i*LANE_W +: LANE_W];
        end
        if (!wr) rdq.push_back({mem[a][0], mem[a][1]});
        accq.push_back({wr, a});
        @(posedge clock);
        #1;
    endtask

    // Takes the oldest note whenever a result appears.
    always @(negedge clock) begin
        if (!rst && rd_valid === 1'b1) begin
            if (rdq.size() == 0) chk("rd_extra", 1, 0);
            else chk("rd_data", {rd_data0, rd_data1}, rdq.pop_front());
        end
        if (!rst && access_pulse === 1'b1) begin
            chk("term_enable", link.term_enable, access_write);
            if (accq.size() == 0) chk("acc_extra", 1, 0);
            else chk("access", {access_write, access_addr}, accq.pop_front());
        end
    end

    initial begin
        int n;
        req_valid = 0;
        req_write = 0;
        req_addr = '0;
        req_data0 = '0;
        req_data1 = '0;
        req_lanes_n0 = '1;
        req_lanes_n1 = '1;
        repeat (2) @(posedge clock);
        #1;
        rst = 0;
        // Back-to-back full writes, then four reads, fill the queue to its depth.
        for (int a = 0; a < 2**AW; a++) op(1, AW'(a), '0, '0);
        for (int a = 0; a < 4; a++) op(0, AW'(a), '1, '1);
        chk("fifo_full", saw_full, 1);
        // Every lane pattern on both beats.
        for (int i = 0; i < 16; i++) op(1, AW'(i), i[1:0], i[3:2]);
        // Each address is read, written, then read again on the shared address bus.
        for (int a = 0; a < 2**AW; a++) begin
            op(0, AW'(a), '1, '1);
            op(1, AW'(a), LN'($random(seed)), LN'($random(seed)));
            op(0, AW'(a), '1, '1);
        end
        req_valid = 0;
        n = 0;
        while ((rdq.size() != 0 || accq.size() != 0) && n < 4000) begin
            n++;
            @(posedge clock);
        end
        repeat (40) @(posedge clock);
        chk("notes_left", rdq.size() + accq.size(), 0);
        finish_test();
    end

    initial begin
        #80000;
        fails++;
        finish_test();
    end
endmodule // tb_top
